// >>> logic/fdma_pkg.sv
package fdma_pkg;
   localparam int NCH = 4;
   localparam int AW = 16;
   localparam int DW = 16;
   localparam int CW = 14;
   localparam int SW = 8;
   // register port map, word indices
   localparam logic [5:0] RA_STAT = 6'h20;
   localparam int RA_AREA_BIT = 5;
   localparam int RA_CH_LSB = 3;
   localparam logic [2:0] RG_CTRL = 3'h0;
   localparam logic [2:0] RG_REQ = 3'h1;
   localparam logic [2:0] RG_STA = 3'h2;
   localparam logic [2:0] RG_STB = 3'h3;
   localparam logic [2:0] RG_PAD = 3'h4;
   localparam logic [2:0] RG_CNT = 3'h5;
   // control word fields
   localparam int CB_EN = 15;
   localparam int CB_SIZE = 14;
   localparam int CB_DIR = 13;
   localparam int CB_HALF = 12;
   localparam int CB_AM = 4;
   localparam int CB_MODE = 0;
   localparam int RB_FORCE = 15;
   localparam logic [15:0] RST_REG = 16'h0000;
   // request codes and their peripheral data addresses
   localparam logic [7:0] RQ_EXT0 = 8'h00;
   localparam logic [7:0] RQ_CAP1 = 8'h01;
   localparam logic [7:0] RQ_CMP1 = 8'h02;
   localparam logic [7:0] RQ_ADC = 8'h0D;
   localparam logic [7:0] RQ_CANRX = 8'h22;
   localparam logic [7:0] RQ_CANTX = 8'h46;
   localparam logic [15:0] PA_CAP1 = 16'h0144;
   localparam logic [15:0] PA_CMP1_PRI = 16'h0906;
   localparam logic [15:0] PA_CMP1_SEC = 16'h0904;
   localparam logic [15:0] PA_ADC = 16'h0300;
   localparam logic [15:0] PA_CANRX = 16'h0440;
   localparam logic [15:0] PA_CANTX = 16'h0442;
   typedef enum logic [1:0] {AM_INC, AM_NOINC, AM_PIA, AM_RSV} fdma_am_t;
   typedef struct packed {
      logic en;
      logic size;
      logic dir;
      logic half;
      fdma_am_t am;
      logic [1:0] mode;
   } fdma_cfg_t;
   typedef struct packed {
      logic req;
      logic we;
      logic byte_sel;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
   } fdma_bus_t;
endpackage

// >>> logic/fdma_ctrl.sv
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module fdma_ctrl
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic [5:0] i_reg_addr,
   input wire logic [15:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [15:0] o_reg_rdata,
   input wire logic [255:0] i_periph_req,
   input wire logic [15:0] i_pia_addr,
   output fdma_pkg::fdma_bus_t o_bus,
   input wire logic i_mem_gnt,
   input wire logic [15:0] i_mem_rdata,
   output logic [3:0] o_chan_done,
   output logic o_busy
);
   typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_RWAIT, ST_WR} fdma_st_t;

   fdma_pkg::fdma_cfg_t cfg_ff [4];
   fdma_pkg::fdma_cfg_t nxt_cfg [4];
   logic [7:0] sel_ff [4];
   logic [7:0] nxt_sel [4];
   logic [15:0] sta_ff [4];
   logic [15:0] nxt_sta [4];
   logic [15:0] stb_ff [4];
   logic [15:0] nxt_stb [4];
   logic [15:0] pad_ff [4];
   logic [15:0] nxt_pad [4];
   logic [13:0] cnt_ff [4];
   logic [13:0] nxt_cnt [4];
   logic [13:0] tcnt_ff [4];
   logic [13:0] nxt_tcnt [4];
   logic [15:0] off_ff [4];
   logic [15:0] nxt_off [4];
   logic [3:0] pp_ff;
   logic [3:0] nxt_pp;
   logic [3:0] pend_ff;
   logic [3:0] nxt_pend;
   logic [3:0] reqd_ff;
   logic [3:0] done_ff;
   logic [3:0] nxt_done;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   fdma_st_t st_ff;
   fdma_st_t nxt_st;
   logic [1:0] chan_ff;
   logic [1:0] nxt_chan;
   logic [15:0] addr_ff;
   logic [15:0] nxt_addr;
   logic [15:0] sram_ff;
   logic [15:0] nxt_sram;
   logic [15:0] data_ff;
   logic [15:0] nxt_data;
   logic [3:0] sreq;
   logic [3:0] go;
   logic wdone;
   logic last;
   logic [1:0] wch;
   logic [2:0] wrg;
   logic wch_area;
   logic [1:0] pk;

   function automatic logic [1:0] pick_chan(input logic [3:0] v);
      pick_chan = 2'h0;
      for (int i = 3; i >= 0; i--)
      begin
         if (v[i])
         begin
            pick_chan = 2'(i);
         end
      end
   endfunction

   // only codes with a known data register load an address
   function automatic logic [15:0] default_pad(input logic [7:0] code, input logic dir,
                                               input logic [15:0] cur);
      default_pad = cur;
      unique case (code)
         fdma_pkg::RQ_EXT0: default_pad = cur;
         fdma_pkg::RQ_CAP1: default_pad = dir ? cur : fdma_pkg::PA_CAP1;
         fdma_pkg::RQ_CMP1: default_pad = dir ? fdma_pkg::PA_CMP1_PRI : cur;
         fdma_pkg::RQ_ADC: default_pad = dir ? cur : fdma_pkg::PA_ADC;
         fdma_pkg::RQ_CANRX: default_pad = dir ? cur : fdma_pkg::PA_CANRX;
         fdma_pkg::RQ_CANTX: default_pad = dir ? fdma_pkg::PA_CANTX : cur;
         default: default_pad = cur;
      endcase
   endfunction

   for (genvar g = 0; g < fdma_pkg::NCH; g++)
   begin : g_ch
      assign sreq[g] = i_periph_req[sel_ff[g]];
      assign go[g] = pend_ff[g] & cfg_ff[g].en;
   end

   assign wch_area = ~i_reg_addr[fdma_pkg::RA_AREA_BIT];
   assign wch = i_reg_addr[fdma_pkg::RA_CH_LSB +: 2];
   assign wrg = i_reg_addr[2:0];
   assign wdone = (st_ff == ST_WR) && i_mem_gnt && i_ce;
   assign last = tcnt_ff[chan_ff] == cnt_ff[chan_ff];
   assign pk = pick_chan(go);

   always_comb
   begin
      o_bus.req = (st_ff == ST_RD) || (st_ff == ST_WR);
      o_bus.we = st_ff == ST_WR;
      o_bus.byte_sel = cfg_ff[chan_ff].size;
      o_bus.addr = addr_ff;
      o_bus.wdata = data_ff;
      o_reg_rdata = rdata_ff;
      o_chan_done = done_ff;
      o_busy = st_ff != ST_IDLE;
   end

   always_comb
   begin
      nxt_cfg = cfg_ff;
      nxt_sel = sel_ff;
      nxt_sta = sta_ff;
      nxt_stb = stb_ff;
      nxt_pad = pad_ff;
      nxt_cnt = cnt_ff;
      nxt_tcnt = tcnt_ff;
      nxt_off = off_ff;
      nxt_pp = pp_ff;
      nxt_pend = pend_ff;
      nxt_done = 4'h0;
      nxt_rdata = rdata_ff;
      nxt_st = st_ff;
      nxt_chan = chan_ff;
      nxt_addr = addr_ff;
      nxt_sram = sram_ff;
      nxt_data = data_ff;
      unique case (st_ff)
         ST_IDLE:
         begin
            if (|go)
            begin
               nxt_chan = pk;
               nxt_pend[pk] = 1'b0;
               if (cfg_ff[pk].am == fdma_pkg::AM_PIA)
               begin
                  nxt_sram = i_pia_addr;
               end
               else
               begin
                  nxt_sram = (pp_ff[pk] ? stb_ff[pk] : sta_ff[pk]) + off_ff[pk];
               end
               // source depends on the fixed direction of the channel
               nxt_addr = cfg_ff[pk].dir ? nxt_sram : pad_ff[pk];
               nxt_st = ST_RD;
            end
         end
         ST_RD:
         begin
            if (i_mem_gnt)
            begin
               nxt_st = ST_RWAIT;
            end
         end
         ST_RWAIT:
         begin
            nxt_data = i_mem_rdata;
            nxt_addr = cfg_ff[chan_ff].dir ? pad_ff[chan_ff] : sram_ff;
            nxt_st = ST_WR;
         end
         ST_WR:
         begin
            if (i_mem_gnt)
            begin
               nxt_st = ST_IDLE;
               if (last)
               begin
                  nxt_tcnt[chan_ff] = 14'h0000;
                  nxt_off[chan_ff] = 16'h0000;
                  nxt_done[chan_ff] = ~cfg_ff[chan_ff].half;
                  if (cfg_ff[chan_ff].mode[0])
                  begin
                     nxt_cfg[chan_ff].en = 1'b0;
                  end
                  if (cfg_ff[chan_ff].mode[1])
                  begin
                     nxt_pp[chan_ff] = ~pp_ff[chan_ff];
                  end
               end
               else
               begin
                  nxt_tcnt[chan_ff] = tcnt_ff[chan_ff] + 14'h0001;
                  if (cfg_ff[chan_ff].am == fdma_pkg::AM_INC)
                  begin
                     // byte steps by one, word by two
                     nxt_off[chan_ff] = off_ff[chan_ff] + (cfg_ff[chan_ff].size ? 16'h0001 : 16'h0002);
                  end
                  nxt_done[chan_ff] = cfg_ff[chan_ff].half && (tcnt_ff[chan_ff] == (cnt_ff[chan_ff] >> 1));
               end
            end
         end
      endcase
      // request edges set after the grant clear, so a new one is kept
      for (int c = 0; c < fdma_pkg::NCH; c++)
      begin
         if (cfg_ff[c].en && sreq[c] && !reqd_ff[c])
         begin
            nxt_pend[c] = 1'b1;
         end
      end
      if (i_reg_wr && wch_area)
      begin
         unique case (wrg)
            fdma_pkg::RG_CTRL:
            begin
               nxt_cfg[wch].en = i_reg_wdata[fdma_pkg::CB_EN];
               nxt_cfg[wch].size = i_reg_wdata[fdma_pkg::CB_SIZE];
               nxt_cfg[wch].dir = i_reg_wdata[fdma_pkg::CB_DIR];
               nxt_cfg[wch].half = i_reg_wdata[fdma_pkg::CB_HALF];
               nxt_cfg[wch].am = fdma_pkg::fdma_am_t'(i_reg_wdata[fdma_pkg::CB_AM +: 2]);
               nxt_cfg[wch].mode = i_reg_wdata[fdma_pkg::CB_MODE +: 2];
               if (i_reg_wdata[fdma_pkg::CB_EN] && !cfg_ff[wch].en)
               begin
                  nxt_tcnt[wch] = 14'h0000;
                  nxt_off[wch] = 16'h0000;
                  nxt_pp[wch] = 1'b0;
                  // stale request from before the disable must not start a block
                  nxt_pend[wch] = 1'b0;
               end
            end
            fdma_pkg::RG_REQ:
            begin
               nxt_sel[wch] = i_reg_wdata[7:0];
               nxt_pad[wch] = default_pad(i_reg_wdata[7:0], cfg_ff[wch].dir, pad_ff[wch]);
               // disabled channels refuse forced requests too
               if (i_reg_wdata[fdma_pkg::RB_FORCE] && cfg_ff[wch].en)
               begin
                  nxt_pend[wch] = 1'b1;
               end
            end
            fdma_pkg::RG_STA: nxt_sta[wch] = i_reg_wdata;
            fdma_pkg::RG_STB: nxt_stb[wch] = i_reg_wdata;
            fdma_pkg::RG_PAD: nxt_pad[wch] = i_reg_wdata;
            fdma_pkg::RG_CNT: nxt_cnt[wch] = i_reg_wdata[13:0];
            default: nxt_sta[wch] = sta_ff[wch];
         endcase
      end
      if (i_reg_rd)
      begin
         nxt_rdata = 16'h0000;
         if (i_reg_addr == fdma_pkg::RA_STAT)
         begin
            nxt_rdata = {3'h0, o_busy, 2'h0, chan_ff, pp_ff, pend_ff};
         end
         else if (wch_area)
         begin
            unique case (wrg)
               fdma_pkg::RG_CTRL: nxt_rdata = {cfg_ff[wch].en, cfg_ff[wch].size, cfg_ff[wch].dir,
                                               cfg_ff[wch].half, 6'h00, cfg_ff[wch].am, 2'h0,
                                               cfg_ff[wch].mode};
               fdma_pkg::RG_REQ: nxt_rdata = {8'h00, sel_ff[wch]};
               fdma_pkg::RG_STA: nxt_rdata = sta_ff[wch];
               fdma_pkg::RG_STB: nxt_rdata = stb_ff[wch];
               fdma_pkg::RG_PAD: nxt_rdata = pad_ff[wch];
               fdma_pkg::RG_CNT: nxt_rdata = {2'h0, cnt_ff[wch]};
               default: nxt_rdata = 16'h0000;
            endcase
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int c = 0; c < fdma_pkg::NCH; c++)
         begin
            cfg_ff[c] <= '0;
            sel_ff[c] <= 8'h00;
            sta_ff[c] <= fdma_pkg::RST_REG;
            stb_ff[c] <= fdma_pkg::RST_REG;
            pad_ff[c] <= fdma_pkg::RST_REG;
            cnt_ff[c] <= 14'h0000;
            tcnt_ff[c] <= 14'h0000;
            off_ff[c] <= 16'h0000;
         end
         pp_ff <= 4'h0;
         pend_ff <= 4'h0;
         reqd_ff <= 4'h0;
         done_ff <= 4'h0;
         rdata_ff <= 16'h0000;
         st_ff <= ST_IDLE;
         chan_ff <= 2'h0;
         addr_ff <= 16'h0000;
         sram_ff <= 16'h0000;
         data_ff <= 16'h0000;
      end
      else if (i_ce)
      begin
         cfg_ff <= nxt_cfg;
         sel_ff <= nxt_sel;
         sta_ff <= nxt_sta;
         stb_ff <= nxt_stb;
         pad_ff <= nxt_pad;
         cnt_ff <= nxt_cnt;
         tcnt_ff <= nxt_tcnt;
         off_ff <= nxt_off;
         pp_ff <= nxt_pp;
         pend_ff <= nxt_pend;
         reqd_ff <= sreq;
         done_ff <= nxt_done;
         rdata_ff <= nxt_rdata;
         st_ff <= nxt_st;
         chan_ff <= nxt_chan;
         addr_ff <= nxt_addr;
         sram_ff <= nxt_sram;
         data_ff <= nxt_data;
      end
   end

   stall_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_bus.req && !i_mem_gnt |=> o_bus.req && $stable(o_bus.addr) && $stable(o_bus.we))
      else $error("request dropped or changed while stalled");
   prio_pick_a: assert property (@(posedge i_clk) disable iff (i_rst)
      st_ff == ST_IDLE && |go && i_ce |=> chan_ff == pick_chan($past(go)) && st_ff == ST_RD)
      else $error("wrong channel picked");
   pend_keep_a: assert property (@(posedge i_clk) disable iff (i_rst)
      st_ff == ST_IDLE && i_ce && go[0] && go[1] && !i_reg_wr && (reqd_ff[0] || !sreq[0])
      |=> pend_ff[1] && !pend_ff[0])
      else $error("losing request not held");
   size_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_bus.req |-> o_bus.byte_sel == cfg_ff[chan_ff].size)
      else $error("transfer size mismatch");
   dir_dest_a: assert property (@(posedge i_clk) disable iff (i_rst)
      st_ff == ST_WR |-> addr_ff == (cfg_ff[chan_ff].dir ? pad_ff[chan_ff] : sram_ff))
      else $error("write goes to wrong side");
   pia_addr_a: assert property (@(posedge i_clk) disable iff (i_rst)
      st_ff == ST_IDLE && |go && i_ce && cfg_ff[pk].am == fdma_pkg::AM_PIA |=> sram_ff == $past(i_pia_addr))
      else $error("peripheral address not used");
   inc_step_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wdone && !last && !i_reg_wr && cfg_ff[chan_ff].am == fdma_pkg::AM_INC
      |=> off_ff[$past(chan_ff)] == $past(off_ff[chan_ff]) + (cfg_ff[$past(chan_ff)].size ? 16'h0001 : 16'h0002))
      else $error("address did not advance");
   noinc_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wdone && !last && !i_reg_wr && cfg_ff[chan_ff].am == fdma_pkg::AM_NOINC
      |=> off_ff[$past(chan_ff)] == $past(off_ff[chan_ff]))
      else $error("address moved in fixed mode");
   oneshot_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wdone && last && !i_reg_wr && cfg_ff[chan_ff].mode[0] |=> !cfg_ff[$past(chan_ff)].en)
      else $error("one-shot channel still enabled");
   pingpong_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wdone && last && !i_reg_wr && cfg_ff[chan_ff].mode[1] |=> pp_ff[$past(chan_ff)] != $past(pp_ff[chan_ff]))
      else $error("buffer not swapped");
   full_done_a: assert property (@(posedge i_clk) disable iff (i_rst)
      wdone && last && !cfg_ff[chan_ff].half |=> o_chan_done[$past(chan_ff)] ##1 !o_chan_done[$past(chan_ff, 2)])
      else $error("block done pulse wrong");
   force_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_ce && i_reg_wr && wch_area && wrg == fdma_pkg::RG_REQ && i_reg_wdata[fdma_pkg::RB_FORCE] && cfg_ff[wch].en
      |=> pend_ff[$past(wch)])
      else $error("forced request lost");
endmodule

// >>> tb/fdma_mem_model.sv
`timescale 1ns/1ps
module fdma_mem_model
(
   input wire logic i_clk,
   input wire logic i_rst,
   input fdma_pkg::fdma_bus_t i_bus,
   input wire logic [3:0] i_stall,
   output logic o_gnt,
   output logic [15:0] o_rdata
);
   logic [7:0] mem [0:65535];
   logic [3:0] wait_ff;
   logic vld_ff;
   logic [15:0] dat_ff;
   // cpu holds the bus for i_stall cycles of every access
   assign o_gnt = i_bus.req && (wait_ff >= i_stall);
   // outside the data cycle the lines carry garbage, not the old value
   assign o_rdata = vld_ff ? dat_ff : ~dat_ff;
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wait_ff <= 4'h0;
         vld_ff <= 1'b0;
         dat_ff <= 16'h0000;
      end
      else
      begin
         wait_ff <= (i_bus.req && !o_gnt) ? wait_ff + 4'h1 : 4'h0;
         vld_ff <= o_gnt && !i_bus.we;
         if (o_gnt && !i_bus.we)
            dat_ff <= i_bus.byte_sel ? {8'h00, mem[i_bus.addr]} : {mem[i_bus.addr + 16'h1], mem[i_bus.addr]};
         if (o_gnt && i_bus.we)
         begin
            mem[i_bus.addr] <= i_bus.wdata[7:0];
            if (!i_bus.byte_sel)
               mem[i_bus.addr + 16'h1] <= i_bus.wdata[15:8];
         end
      end
   end
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
   typedef struct {logic [7:0] code; logic dir; logic [15:0] pad;} fdma_row_t;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_ce = 1'b1;
   logic [5:0] reg_addr = 6'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [255:0] preq = 256'h0;
   logic [15:0] pia_addr = 16'h0000;
   logic [3:0] stall = 4'h0;
   fdma_pkg::fdma_bus_t bus;
   logic gnt;
   logic [15:0] mem_rdata;
   logic [3:0] chan_done;
   logic busy;
   int n_mismatch = 0;
   int total_checks = 0;
   int base;
   logic [15:0] wa [$];
   logic [15:0] wd [$];
   logic wb [$];
   int done_cnt [4] = '{0, 0, 0, 0};
   int done_at [4] = '{0, 0, 0, 0};
   fdma_row_t rows [6];
   fdma_ctrl fdma_ctrl_inst
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_reg_addr(reg_addr),
      .i_reg_wdata(reg_wdata),
      .i_reg_wr(reg_wr),
      .i_reg_rd(reg_rd),
      .o_reg_rdata(reg_rdata),
      .i_periph_req(preq),
      .i_pia_addr(pia_addr),
      .o_bus(bus),
      .i_mem_gnt(gnt),
      .i_mem_rdata(mem_rdata),
      .o_chan_done(chan_done),
      .o_busy(busy)
   );
   fdma_mem_model fdma_mem_model_inst
   (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_bus(bus),
      .i_stall(stall),
      .o_gnt(gnt),
      .o_rdata(mem_rdata)
   );
   always #10 i_clk = ~i_clk;
   // log of accepted writes and done pulses
   always @(posedge i_clk)
   begin
      if (bus.req && bus.we && gnt)
      begin
         wa.push_back(bus.addr);
         wd.push_back(bus.wdata);
         wb.push_back(bus.byte_sel);
      end
      for (int c = 0; c < 4; c++)
         if (chan_done[c] === 1'b1)
         begin
            done_cnt[c]++;
            done_at[c] = wa.size();
         end
   end
   function automatic logic [5:0] ra(input logic [1:0] ch, input logic [2:0] r);
      return {1'b0, ch, r};
   endfunction
   task automatic report_and_stop();
      if (n_mismatch == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // strobe released with one idle edge so a following call never reassigns it in the same step
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge i_clk);
      reg_wr <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic rd(input logic [5:0] a, input logic [15:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge i_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
      @(posedge i_clk);
   endtask
   task automatic wait_wr(input int n);
      int k;
      k = 0;
      while (wa.size() < n && k < 200)
      begin
         @(posedge i_clk);
         k++;
      end
      if (k >= 200)
      begin
         n_mismatch++;
         report_and_stop();
      end
      repeat (3) @(posedge i_clk);
   endtask
   task automatic cfg(input logic [1:0] ch, input logic [15:0] ctl, input logic [7:0] code,
                      input logic [15:0] sta, input logic [15:0] stb, input logic [15:0] pad, input logic [15:0] cnt);
      wr(ra(ch, fdma_pkg::RG_CTRL), ctl & 16'h7FFF);
      wr(ra(ch, fdma_pkg::RG_REQ), {8'h00, code});
      wr(ra(ch, fdma_pkg::RG_STA), sta);
      wr(ra(ch, fdma_pkg::RG_STB), stb);
      wr(ra(ch, fdma_pkg::RG_PAD), pad);
      wr(ra(ch, fdma_pkg::RG_CNT), cnt);
      wr(ra(ch, fdma_pkg::RG_CTRL), ctl);
   endtask
   // peripheral holds its line until the transfers it asked for are done
   task automatic trig(input logic [7:0] code, input int n);
      preq[code] <= 1'b1;
      wait_wr(n);
      preq[code] <= 1'b0;
      @(posedge i_clk);
   endtask
   task automatic chkw(input int i, input logic [15:0] a, input logic [15:0] d);
      `CHK(wa[i], a)
      `CHK(wd[i], d)
   endtask
   initial
   begin
      #1500000;
      n_mismatch++;
      report_and_stop();
   end
   initial
   begin
      rows = '{'{fdma_pkg::RQ_EXT0, 1'b0, 16'h0ABC}, '{fdma_pkg::RQ_CAP1, 1'b0, 16'h0144},
               '{fdma_pkg::RQ_CMP1, 1'b1, 16'h0906}, '{fdma_pkg::RQ_ADC, 1'b0, 16'h0300},
               '{fdma_pkg::RQ_CANRX, 1'b0, 16'h0440}, '{fdma_pkg::RQ_CANTX, 1'b1, 16'h0442}};
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      for (int i = 0; i < 6; i++)
      begin
         wr(ra(1, fdma_pkg::RG_CTRL), {2'h0, rows[i].dir, 13'h0000});
         wr(ra(1, fdma_pkg::RG_PAD), 16'h0ABC);
         wr(ra(1, fdma_pkg::RG_REQ), {8'h00, rows[i].code});
         rd(ra(1, fdma_pkg::RG_PAD), rows[i].pad);
      end
      i_rst <= 1'b1;
      @(posedge i_clk);
      #1;
      `CHK({busy, chan_done, bus.req}, 6'h00)
      @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      rd(ra(1, fdma_pkg::RG_CTRL), 16'h0000);
      rd(fdma_pkg::RA_STAT, 16'h0000);
      wr(ra(0, fdma_pkg::RG_CNT), 16'hFFFF);
      rd(ra(0, fdma_pkg::RG_CNT), 16'h3FFF);
      i_ce <= 1'b0;
      wr(ra(0, fdma_pkg::RG_STA), 16'h0005);
      i_ce <= 1'b1;
      rd(ra(0, fdma_pkg::RG_STA), 16'h0000);
      wr(6'h06, 16'hFFFF);
      rd(6'h06, 16'h0000);
      // word, sram to peripheral, incrementing, one-shot, forced by software
      for (int i = 0; i < 4; i++)
      begin
         fdma_mem_model_inst.mem[16'h1000 + 2 * i] = 8'(i);
         fdma_mem_model_inst.mem[16'h1001 + 2 * i] = 8'h11;
      end
      stall <= 4'h2;
      cfg(0, 16'hA001, 8'hFF, 16'h1000, 16'h0000, 16'h0500, 16'h0003);
      base = wa.size();
      for (int i = 0; i < 4; i++)
      begin
         wr(ra(0, fdma_pkg::RG_REQ), 16'h80FF);
         wait_wr(base + i + 1);
      end
      for (int i = 0; i < 4; i++)
         chkw(base + i, 16'h0500, 16'(16'h1100 + i));
      `CHK(done_cnt[0], 1)
      `CHK(done_at[0], base + 4)
      wr(ra(0, fdma_pkg::RG_REQ), 16'h80FF);
      repeat (30) @(posedge i_clk);
      `CHK(wa.size(), base + 4)
      // byte, peripheral to sram, fixed address, half-block pulse
      stall <= 4'h0;
      cfg(1, 16'hD011, fdma_pkg::RQ_ADC, 16'h4000, 16'h0000, 16'h0300, 16'h0003);
      base = wa.size();
      for (int i = 0; i < 4; i++)
      begin
         fdma_mem_model_inst.mem[16'h0300] = 8'(8'h30 + i);
         trig(fdma_pkg::RQ_ADC, base + i + 1);
      end
      for (int i = 0; i < 4; i++)
      begin
         `CHK({wa[base + i], wb[base + i]}, {16'h4000, 1'b1})
         `CHK(wd[base + i][7:0], 8'(8'h30 + i))
      end
      `CHK(done_cnt[1], 1)
      `CHK(done_at[1], base + 2)
      // peripheral-indirect destination
      fdma_mem_model_inst.mem[16'h0144] = 8'hCD;
      fdma_mem_model_inst.mem[16'h0145] = 8'hAB;
      pia_addr <= 16'h5554;
      cfg(2, 16'h8021, fdma_pkg::RQ_CAP1, 16'h0000, 16'h0000, 16'h0144, 16'h0000);
      base = wa.size();
      trig(fdma_pkg::RQ_CAP1, base + 1);
      chkw(base, 16'h5554, 16'hABCD);
      wr(ra(2, fdma_pkg::RG_CTRL), 16'h0000);
      // ping-pong with auto-repeat, external interrupt trigger
      fdma_mem_model_inst.mem[16'h0600] = 8'h77;
      fdma_mem_model_inst.mem[16'h0601] = 8'h66;
      cfg(3, 16'h8002, fdma_pkg::RQ_EXT0, 16'h2000, 16'h3000, 16'h0600, 16'h0000);
      base = wa.size();
      for (int i = 0; i < 3; i++)
         trig(fdma_pkg::RQ_EXT0, base + i + 1);
      for (int i = 0; i < 3; i++)
         chkw(base + i, (i == 1) ? 16'h3000 : 16'h2000, 16'h6677);
      `CHK(done_cnt[3], 3)
      wr(ra(3, fdma_pkg::RG_CTRL), 16'h0000);
      // two channels pending at once under a stalling arbiter
      stall <= 4'h3;
      cfg(1, 16'h8001, fdma_pkg::RQ_CAP1, 16'h6100, 16'h0000, 16'h0144, 16'h0000);
      cfg(0, 16'h8001, fdma_pkg::RQ_CAP1, 16'h6000, 16'h0000, 16'h0144, 16'h0000);
      base = wa.size();
      trig(fdma_pkg::RQ_CAP1, base + 2);
      chkw(base, 16'h6000, 16'hABCD);
      chkw(base + 1, 16'h6100, 16'hABCD);
      repeat (20) @(posedge i_clk);
      `CHK(wa.size(), base + 2)
      // reset after both runs have finished clears the registers
      wr(ra(0, fdma_pkg::RG_STA), 16'h1234);
      i_rst <= 1'b1;
      @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      rd(ra(0, fdma_pkg::RG_STA), 16'h0000);
      `CHK(busy, 1'b0)
      report_and_stop();
   end
endmodule
